// ---- rtl/static_link_forwarding.sv ----
// Purpose: Static forwarding control for eight external links
// Assumes: AXI4-Lite slave, one write and one read in flight
// Notes: Unmapped or misaligned addresses answer SLVERR
`timescale 1ns/1ns
module static_link_forwarding #(
   parameter int NUM_LINKS = slf_pkg::NUM_LINKS,
   parameter int DATA_W = slf_pkg::DATA_W
) (
   input wire logic CLK,
   input wire logic RST_N,
   input wire logic [slf_pkg::ADDR_W-1:0] S_AXI_AWADDR,
   input wire logic S_AXI_AWVALID,
   output logic S_AXI_AWREADY,
   input wire logic [31:0] S_AXI_WDATA,
   input wire logic [3:0] S_AXI_WSTRB,
   input wire logic S_AXI_WVALID,
   output logic S_AXI_WREADY,
   output logic [1:0] S_AXI_BRESP,
   output logic S_AXI_BVALID,
   input wire logic S_AXI_BREADY,
   input wire logic [slf_pkg::ADDR_W-1:0] S_AXI_ARADDR,
   input wire logic S_AXI_ARVALID,
   output logic S_AXI_ARREADY,
   output logic [31:0] S_AXI_RDATA,
   output logic [1:0] S_AXI_RRESP,
   output logic S_AXI_RVALID,
   input wire logic S_AXI_RREADY,
   input wire logic [NUM_LINKS-1:0] LINK_RX_VALID,
   input wire logic [NUM_LINKS-1:0][DATA_W-1:0] LINK_RX_DATA,
   output logic [NUM_LINKS-1:0] CHANEND_VALID,
   output logic [NUM_LINKS-1:0][slf_pkg::CHANEND_W-1:0] CHANEND_DEST,
   output logic [NUM_LINKS-1:0][DATA_W-1:0] CHANEND_DATA,
   output logic [NUM_LINKS-1:0] LOOKUP_VALID,
   output logic [NUM_LINKS-1:0][DATA_W-1:0] LOOKUP_DATA
);

   localparam int SLOT_W = slf_pkg::SLOT_W;

   logic awready_q, wready_q, arready_q;
   logic aw_hold_q, w_hold_q, bvalid_q, rvalid_q;
   logic [slf_pkg::ADDR_W-1:0] aw_addr_q;
   logic [31:0] w_data_q, rdata_q;
   logic [3:0] w_strb_q;
   logic [1:0] bresp_q, rresp_q;
   logic [NUM_LINKS-1:0] en_q;
   logic [NUM_LINKS-1:0][slf_pkg::CHANEND_W-1:0] dest_q;
   logic wr_commit;
   logic wr_hit, rd_hit;
   logic [SLOT_W-1:0] wr_slot, rd_slot;

   slf_cfg_if cfg ();

   ////////////////////////////////////////////////////////////////////////
   // Word index range check; slot is offset from the first register
   function automatic logic [SLOT_W:0] decode(input logic [slf_pkg::ADDR_W-1:0] addr);
      logic [9:0] idx;
      logic [9:0] off;
      idx = addr[slf_pkg::ADDR_W-1:slf_pkg::WORD_SHIFT];
      off = idx - slf_pkg::IDX_LINK_C;
      if (addr[slf_pkg::WORD_SHIFT-1:0] != 2'h0)
         decode = '0;
      else if (idx < slf_pkg::IDX_LINK_C)
         decode = '0;
      else if (idx > slf_pkg::IDX_LINK_F)
         decode = '0;
      else
         decode = {1'b1, off[SLOT_W-1:0]};
   endfunction

   assign {wr_hit, wr_slot} = decode(aw_addr_q);
   assign {rd_hit, rd_slot} = decode(S_AXI_ARADDR);
   assign wr_commit = aw_hold_q && w_hold_q && !bvalid_q;

   ////////////////////////////////////////////////////////////////////////
   // Write channels: address and data taken in either order
   always_ff @(posedge CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         awready_q <= 1'b0;
         aw_hold_q <= 1'b0;
         aw_addr_q <= '0;
      end
      else if (awready_q && S_AXI_AWVALID)
      begin
         awready_q <= 1'b0;
         aw_hold_q <= 1'b1;
         aw_addr_q <= S_AXI_AWADDR;
      end
      else if (wr_commit)
         aw_hold_q <= 1'b0;
      else if (!aw_hold_q && !bvalid_q)
         awready_q <= 1'b1;
   end

   always_ff @(posedge CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         wready_q <= 1'b0;
         w_hold_q <= 1'b0;
         w_data_q <= '0;
         w_strb_q <= '0;
      end
      else if (wready_q && S_AXI_WVALID)
      begin
         wready_q <= 1'b0;
         w_hold_q <= 1'b1;
         w_data_q <= S_AXI_WDATA;
         w_strb_q <= S_AXI_WSTRB;
      end
      else if (wr_commit)
         w_hold_q <= 1'b0;
      else if (!w_hold_q && !bvalid_q)
         wready_q <= 1'b1;
   end

   always_ff @(posedge CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         bvalid_q <= 1'b0;
         bresp_q <= slf_pkg::RESP_OKAY;
      end
      else if (wr_commit)
      begin
         bvalid_q <= 1'b1;
         bresp_q <= wr_hit ? slf_pkg::RESP_OKAY : slf_pkg::RESP_SLVERR;
      end
      else if (bvalid_q && S_AXI_BREADY)
         bvalid_q <= 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////
   // Config registers; byte lanes 1 and 2 hold only reserved bits
   always_ff @(posedge CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         en_q <= {NUM_LINKS{slf_pkg::EN_RESET}};
         dest_q <= {NUM_LINKS{slf_pkg::DEST_RESET}};
      end
      else if (wr_commit && wr_hit)
      begin
         if (w_strb_q[3])
            en_q[wr_slot] <= w_data_q[slf_pkg::ENABLE_BIT];
         if (w_strb_q[0])
            dest_q[wr_slot] <= w_data_q[slf_pkg::DEST_MSB:slf_pkg::DEST_LSB];
      end
   end

   assign cfg.en = en_q;
   assign cfg.dest = dest_q;

   ////////////////////////////////////////////////////////////////////////
   // Read channel
   always_ff @(posedge CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         arready_q <= 1'b0;
         rvalid_q <= 1'b0;
         rdata_q <= '0;
         rresp_q <= slf_pkg::RESP_OKAY;
      end
      else if (arready_q && S_AXI_ARVALID)
      begin
         arready_q <= 1'b0;
         rvalid_q <= 1'b1;
         rresp_q <= rd_hit ? slf_pkg::RESP_OKAY : slf_pkg::RESP_SLVERR;
         rdata_q <= '0;
         if (rd_hit)
         begin
            rdata_q[slf_pkg::ENABLE_BIT] <= en_q[rd_slot];
            rdata_q[slf_pkg::DEST_MSB:slf_pkg::DEST_LSB] <= dest_q[rd_slot];
         end
      end
      else if (rvalid_q && S_AXI_RREADY)
         rvalid_q <= 1'b0;
      else if (!rvalid_q)
         arready_q <= 1'b1;
   end

   assign S_AXI_AWREADY = awready_q;
   assign S_AXI_WREADY = wready_q;
   assign S_AXI_BVALID = bvalid_q;
   assign S_AXI_BRESP = bresp_q;
   assign S_AXI_ARREADY = arready_q;
   assign S_AXI_RVALID = rvalid_q;
   assign S_AXI_RDATA = rdata_q;
   assign S_AXI_RRESP = rresp_q;

   ////////////////////////////////////////////////////////////////////////
   slf_link_forwarder #(
      .NUM_LINKS(NUM_LINKS),
      .DATA_W(DATA_W)
   ) u_fwd (
      .clk(CLK),
      .rst_n(RST_N),
      .cfg(cfg.fwd),
      .rx_valid(LINK_RX_VALID),
      .rx_data(LINK_RX_DATA),
      .chan_valid_q(CHANEND_VALID),
      .chan_dest_q(CHANEND_DEST),
      .chan_data_q(CHANEND_DATA),
      .lookup_valid_q(LOOKUP_VALID),
      .lookup_data_q(LOOKUP_DATA)
   );

   ////////////////////////////////////////////////////////////////////////
   logic up_q;
   always_ff @(posedge CLK or negedge RST_N)
   begin
      if (!RST_N)
         up_q <= 1'b0;
      else
         up_q <= 1'b1;
   end

   AST_RESET_CLEAR: assert property (
      @(posedge CLK) disable iff (!RST_N)
      !up_q |-> en_q == '0 && dest_q == '0)
      else $error("config not cleared by reset");
   AST_RSVD_ZERO: assert property (
      @(posedge CLK) disable iff (!RST_N)
      S_AXI_RVALID |-> S_AXI_RDATA[slf_pkg::RSVD_MSB:slf_pkg::RSVD_LSB] == '0)
      else $error("reserved bits read nonzero");
   AST_LINK_C_FIRST: assert property (
      @(posedge CLK) disable iff (!RST_N)
      S_AXI_ARREADY && S_AXI_ARVALID
      && S_AXI_ARADDR == {slf_pkg::IDX_LINK_C, 2'h0}
      |=> S_AXI_RDATA[slf_pkg::ENABLE_BIT] == $past(en_q[0])
      && S_AXI_RRESP == slf_pkg::RESP_OKAY)
      else $error("first register not mapped to link C lane");
   AST_LINK_F_LAST: assert property (
      @(posedge CLK) disable iff (!RST_N)
      wr_commit && aw_addr_q == {slf_pkg::IDX_LINK_F, 2'h0} && w_strb_q[0]
      |=> dest_q[7] == $past(w_data_q[slf_pkg::DEST_MSB:slf_pkg::DEST_LSB]))
      else $error("last register not mapped to link F lane");
   AST_WRITE_RESP: assert property (
      @(posedge CLK) disable iff (!RST_N)
      S_AXI_AWVALID && S_AXI_WVALID && S_AXI_AWREADY && S_AXI_WREADY
      |=> ##1 S_AXI_BVALID)
      else $error("write response not given two cycles after handshake");

   COV_WRITE: cover property (@(posedge CLK) disable iff (!RST_N) wr_commit && wr_hit);
   COV_READ_ERR: cover property (@(posedge CLK) disable iff (!RST_N)
      S_AXI_RVALID && S_AXI_RRESP == slf_pkg::RESP_SLVERR);
   COV_ENABLE: cover property (@(posedge CLK) disable iff (!RST_N) $rose(en_q[2]));
endmodule // static_link_forwarding

// ---- rtl/slf_pkg.sv ----
// Purpose: Shared constants for the per-link static forwarding block
// Assumes: AXI4-Lite register access, 32-bit data
// Notes: Register indexes are word indexes; byte address is index times four
package slf_pkg;
   localparam int NUM_LINKS = 8;
   localparam int CHANEND_W = 5;
   localparam int DATA_W = 8;
   localparam int ADDR_W = 12;
   localparam int ENABLE_BIT = 31;
   localparam int DEST_LSB = 0;
   localparam int DEST_MSB = 4;
   localparam int RSVD_LSB = 5;
   localparam int RSVD_MSB = 30;
   localparam int WORD_SHIFT = 2;
   localparam int SLOT_W = 3;
   // Register index per link, lowest first: C D A B G H E F
   localparam logic [9:0] IDX_LINK_C = 10'h0a0;
   localparam logic [9:0] IDX_LINK_D = 10'h0a1;
   localparam logic [9:0] IDX_LINK_A = 10'h0a2;
   localparam logic [9:0] IDX_LINK_B = 10'h0a3;
   localparam logic [9:0] IDX_LINK_G = 10'h0a4;
   localparam logic [9:0] IDX_LINK_H = 10'h0a5;
   localparam logic [9:0] IDX_LINK_E = 10'h0a6;
   localparam logic [9:0] IDX_LINK_F = 10'h0a7;
   localparam logic EN_RESET = 1'h0;
   localparam logic [CHANEND_W-1:0] DEST_RESET = 5'h00;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ---- rtl/slf_cfg_if.sv ----
// Purpose: Carries the per-link static configuration to the forwarder
// Assumes: Driven only by the register slave
// Notes: Lane k belongs to register k in address order
`timescale 1ns/1ns
interface slf_cfg_if;
   logic [slf_pkg::NUM_LINKS-1:0] en;
   logic [slf_pkg::NUM_LINKS-1:0][slf_pkg::CHANEND_W-1:0] dest;
   modport ctrl (output en, output dest);
   modport fwd (input en, input dest);
endinterface

// ---- rtl/slf_link_forwarder.sv ----
// Purpose: Per-link split between static delivery and routing lookup
// Assumes: Consumers always accept; one token per link per cycle
// Notes: One cycle latency, outputs registered
`timescale 1ns/1ns
module slf_link_forwarder #(
   parameter int NUM_LINKS = slf_pkg::NUM_LINKS,
   parameter int DATA_W = slf_pkg::DATA_W
) (
   input wire logic clk,
   input wire logic rst_n,
   slf_cfg_if.fwd cfg,
   input wire logic [NUM_LINKS-1:0] rx_valid,
   input wire logic [NUM_LINKS-1:0][DATA_W-1:0] rx_data,
   output logic [NUM_LINKS-1:0] chan_valid_q,
   output logic [NUM_LINKS-1:0][slf_pkg::CHANEND_W-1:0] chan_dest_q,
   output logic [NUM_LINKS-1:0][DATA_W-1:0] chan_data_q,
   output logic [NUM_LINKS-1:0] lookup_valid_q,
   output logic [NUM_LINKS-1:0][DATA_W-1:0] lookup_data_q
);

   ////////////////////////////////////////////////////////////////////////
   for (genvar i = 0; i < NUM_LINKS; i++)
   begin : g_link
      always_ff @(posedge clk or negedge rst_n)
      begin
         if (!rst_n)
         begin
            chan_valid_q[i] <= 1'b0;
            lookup_valid_q[i] <= 1'b0;
         end
         else
         begin
            // Header is never inspected in static mode
            chan_valid_q[i] <= rx_valid[i] && cfg.en[i];
            lookup_valid_q[i] <= rx_valid[i] && !cfg.en[i];
         end
      end

      // Payload regs need no reset; qualified by the valids
      always_ff @(posedge clk)
      begin
         if (rx_valid[i])
         begin
            chan_dest_q[i] <= cfg.dest[i];
            chan_data_q[i] <= rx_data[i];
            lookup_data_q[i] <= rx_data[i];
         end
      end

      //////////////////////////////////////////////////////////////////////
      AST_STATIC_DELIVER: assert property (
         @(posedge clk) disable iff (!rst_n)
         rx_valid[i] && cfg.en[i] |=> chan_valid_q[i] && chan_data_q[i] == $past(rx_data[i]))
         else $error("static token not delivered to channel end");
      AST_NO_LOOKUP: assert property (
         @(posedge clk) disable iff (!rst_n)
         rx_valid[i] && cfg.en[i] |=> !lookup_valid_q[i])
         else $error("routing lookup issued on a static link");
      AST_DEST_SELECT: assert property (
         @(posedge clk) disable iff (!rst_n)
         rx_valid[i] && cfg.en[i] |=> chan_dest_q[i] == $past(cfg.dest[i]))
         else $error("static token sent to wrong channel end");
      AST_ROUTED_PATH: assert property (
         @(posedge clk) disable iff (!rst_n)
         rx_valid[i] && !cfg.en[i] |=> lookup_valid_q[i] && !chan_valid_q[i])
         else $error("routed token took the static path");
   end

   COV_STATIC: cover property (@(posedge clk) disable iff (!rst_n) chan_valid_q[0]);
   COV_ROUTED: cover property (@(posedge clk) disable iff (!rst_n) lookup_valid_q[7]);
endmodule // slf_link_forwarder

// ---- testbench/remote_switch_model.sv ----
// Purpose: Far-side switch that puts tokens onto the eight links
// Assumes: One token per link per cycle, no credit flow
// Notes: Idle data lines flip every cycle so stale data never matches
`timescale 1ns/1ns
module remote_switch_model (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [7:0] req_valid,
   input wire logic [7:0][7:0] req_data,
   output logic [7:0] rx_valid,
   output logic [7:0][7:0] rx_data
);
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rx_valid <= 8'h00;
         rx_data <= '0;
      end
      else
      begin
         rx_valid <= req_valid;
         for (int k = 0; k < 8; k++)
            rx_data[k] <= req_valid[k] ? req_data[k] : ~rx_data[k];
      end
   end
endmodule // remote_switch_model

// ---- testbench/test_static_link_forwarding.sv ----
// Purpose: Self-checking bench for the static link forwarding block
// Assumes: Register slave answers on its own schedule
// Notes: A local mirror of every register predicts link outcomes
`timescale 1ns/1ns
module test_static_link_forwarding;
   logic clk, rst_n, awvalid, wvalid, bready, arvalid, rready;
   logic awready, wready, bvalid, arready, rvalid;
   logic [11:0] awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp;
   logic [7:0] req_valid, rx_valid, chan_valid, look_valid, cfg_en;
   logic [7:0][7:0] req_data, rx_data, chan_data, look_data;
   logic [7:0][4:0] chan_dest, cfg_dest;
   int error_cnt, n_tests;
   static_link_forwarding static_link_forwarding_inst (.CLK(clk), .RST_N(rst_n),
      .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
      .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid),
      .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
      .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
      .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
      .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .LINK_RX_VALID(rx_valid),
      .LINK_RX_DATA(rx_data), .CHANEND_VALID(chan_valid), .CHANEND_DEST(chan_dest),
      .CHANEND_DATA(chan_data), .LOOKUP_VALID(look_valid), .LOOKUP_DATA(look_data));
   remote_switch_model remote_switch_model_inst (.clk(clk), .rst_n(rst_n),
      .req_valid(req_valid), .req_data(req_data), .rx_valid(rx_valid), .rx_data(rx_data));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic complete_run();
      $display("Counts: %0d mismatches in %0d comparisons", error_cnt, n_tests);
      if (error_cnt == 0 && n_tests > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      n_tests++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("ERROR at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask
   task automatic hang();
      error_cnt++;
      $display("ERROR at %0t: bus answer never came", $time);
      complete_run();
   endtask
   function automatic logic [11:0] ra(input int k);
      return 12'(slf_pkg::IDX_LINK_C) * 12'h004 + 12'(k * 4);
   endfunction
   ////////////////////////////////////////////////////////////////////////////////
   task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
      input logic [1:0] er);
      int n;
      @(posedge clk);
      awaddr <= a;
      wdata <= d;
      wstrb <= s;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (n = 0; n < 64; n++)
      begin
         @(posedge clk);
         if (awready === 1'b1)
            awvalid <= 1'b0;
         if (wready === 1'b1)
            wvalid <= 1'b0;
         if (bvalid === 1'b1)
            break;
      end
      if (n == 64)
         hang();
      bready <= 1'b0;
      chk({30'h0, bresp}, {30'h0, er}, "write response");
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
      int n;
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (n = 0; n < 64; n++)
      begin
         @(posedge clk);
         if (arready === 1'b1)
            arvalid <= 1'b0;
         if (rvalid === 1'b1)
            break;
      end
      if (n == 64)
         hang();
      rready <= 1'b0;
      chk(rdata, ed, "read data");
      chk({30'h0, rresp}, {30'h0, er}, "read response");
   endtask
   task automatic setc(input int k, input logic en, input logic [4:0] dest);
      wr(ra(k), {en, 26'h0, dest}, 4'hf, slf_pkg::RESP_OKAY);
      cfg_en[k] = en;
      cfg_dest[k] = dest;
   endtask
   // Tokens on the chosen lanes, then one idle cycle must follow
   task automatic tok(input logic [7:0] lanes);
      int k;
      @(posedge clk);
      req_valid <= lanes;
      for (k = 0; k < 8; k++)
         req_data[k] <= 8'ha0 ^ 8'(k * 17);
      @(posedge clk);
      req_valid <= 8'h00;
      @(posedge clk);
      #1;
      chk({24'h0, chan_valid}, {24'h0, lanes & cfg_en}, "static valid");
      chk({24'h0, look_valid}, {24'h0, lanes & ~cfg_en}, "lookup valid");
      for (k = 0; k < 8; k++)
      begin
         if (lanes[k] && cfg_en[k])
         begin
            chk({24'h0, chan_data[k]}, {24'h0, 8'ha0 ^ 8'(k * 17)}, "static data");
            chk({27'h0, chan_dest[k]}, {27'h0, cfg_dest[k]}, "channel end");
         end
         if (lanes[k] && !cfg_en[k])
            chk({24'h0, look_data[k]}, {24'h0, 8'ha0 ^ 8'(k * 17)}, "lookup data");
      end
      @(posedge clk);
      #1;
      chk({16'h0, chan_valid, look_valid}, 32'h0, "single pulse");
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   task automatic sc_reset();
      for (int k = 0; k < 8; k++)
         rd(ra(k), 32'h0, slf_pkg::RESP_OKAY);
      tok(8'hff);
   endtask
   // Mid-run reset must drop every link back to routed mode
   task automatic sc_rst();
      @(posedge clk);
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      cfg_en = 8'h00;
      cfg_dest = '0;
      for (int k = 0; k < 8; k++)
         rd(ra(k), 32'h0, slf_pkg::RESP_OKAY);
      tok(8'hff);
   endtask
   task automatic sc_map();
      for (int k = 0; k < 8; k++)
         setc(k, 1'b1, 5'(3 * k + 1));
      setc(5, 1'b0, 5'h0a);
      wr(ra(2), 32'hffffffff, 4'hf, slf_pkg::RESP_OKAY);
      cfg_dest[2] = 5'h1f;
      for (int k = 0; k < 8; k++)
         rd(ra(k), {cfg_en[k], 26'h0, cfg_dest[k]}, slf_pkg::RESP_OKAY);
      tok(8'hff);
      tok(8'h24);
   endtask
   // Byte strobes split enable and channel end updates
   task automatic sc_strb();
      wr(ra(0), 32'h00000009, 4'h1, slf_pkg::RESP_OKAY);
      cfg_dest[0] = 5'h09;
      rd(ra(0), 32'h80000009, slf_pkg::RESP_OKAY);
      wr(ra(0), 32'h7fffffe0, 4'h8, slf_pkg::RESP_OKAY);
      cfg_en[0] = 1'b0;
      rd(ra(0), 32'h00000009, slf_pkg::RESP_OKAY);
      tok(8'h01);
   endtask
   task automatic sc_bad();
      wr(12'h2a0, 32'h80000000, 4'hf, slf_pkg::RESP_SLVERR);
      rd(12'h2a0, 32'h0, slf_pkg::RESP_SLVERR);
      rd(12'h282, 32'h0, slf_pkg::RESP_SLVERR);
      tok(8'hff);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   initial
   begin
      rst_n = 1'b0;
      {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
      {awaddr, araddr, wdata, wstrb} = '0;
      req_valid = 8'h00;
      req_data = '0;
      cfg_en = 8'h00;
      cfg_dest = '0;
      error_cnt = 0;
      n_tests = 0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      sc_reset();
      sc_map();
      sc_strb();
      sc_bad();
      sc_rst();
      complete_run();
   end
endmodule // test_static_link_forwarding
